/* File: bench/fq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module fq_assertions (
   // Clock and reset
   input wire logic                  i_mclk,
   input wire logic                  i_arst_n,
   // Link signals
   input wire logic [fq_pkg::AW-1:0] addr,
   input wire logic [fq_pkg::DW-1:0] wdata,
   input wire logic                  wr,
   input wire logic                  rd,
   input wire logic [fq_pkg::DW-1:0] rdata,
   input wire logic                  big_endian,
   input wire logic                  irq_n
);
   logic ie_r;
   logic qc3_r;
   logic fresh_r;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // Shadow state, so the link alone tells when a dummy read is due
   wire w_qc = wr && addr == fq_pkg::OFF_QCTL;
   wire rd_dat = rd && addr == fq_pkg::OFF_DATA;
   wire ie_nxt = (wr && addr == fq_pkg::OFF_IER) ? wdata[13] : ie_r;
   wire qc3_nxt = w_qc ? wdata[3] : qc3_r;
   wire fresh_nxt = (w_qc && wdata[3] && !qc3_r) || (fresh_r && !rd_dat);
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ie_r    <= 1'b0;
         qc3_r   <= 1'b0;
         fresh_r <= 1'b0;
      end else begin
         ie_r    <= ie_nxt;
         qc3_r   <= qc3_nxt;
         fresh_r <= fresh_nxt;
      end
   end
   sequence s_first_rd;
      rd_dat && fresh_r;
   endsequence
   sequence s_clear;
      wr && addr == fq_pkg::OFF_ISR && wdata[13];
   endsequence
   AST_DUMMY: assert property (s_first_rd |=> rdata == 16'h0000)
      else $error("first data read not dummy");
   AST_IRQ_OFF: assert property (!ie_r && !$past(ie_r) |-> irq_n)
      else $error("interrupt while disabled");
   AST_ISR_CLR: assert property (s_clear |-> ##[1:2] irq_n)
      else $error("interrupt not cleared");
   AST_RFC: assert property (rd && addr == fq_pkg::OFF_RFC |=>
      rdata[7:0] == 8'h00) else $error("frame count low byte set");
   AST_HCNT: assert property (rd && addr == fq_pkg::OFF_HCNT |=>
      rdata[15:12] == 4'h0) else $error("byte count upper bits set");
   AST_QC: assert property (rd && addr == fq_pkg::OFF_QCTL |=>
      (rdata & 16'hE306) == 16'h0000) else $error("queue control bits");
   AST_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside answer cycle");
   AST_UNMAP: assert property (rd && addr == 9'h100 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: bench/host_frame_queue_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module host_frame_queue_access_tb;
   logic clk, rst_n, wr, rd, tx_start, tx_valid, rx_start, f_valid, f_end;
   logic busy, irq, tx_ready, rx_valid, rx_last, flow, hdr, t_valid, t_last;
   logic [8:0]  addr;
   logic [15:0] wdata, f_word, f_status, rdata, tx_word, tx_ctrl, w;
   logic [15:0] rx_word, rx_status, t_ctrl, t_word, q[$], st[$], tq[$];
   logic [11:0] tx_len, t_count;
   logic [3:0]  csum_en;
   logic        be;
   int num_errors = 0, num_checks = 0, cyc = 0;
   fq_if link ();
   fq_device #(.DEPTH(2048), .FRAMES(16)) fq_device_i (
      .i_mclk(clk), .i_arst_n(rst_n), .bus(link.dev), .i_rx_valid(f_valid),
      .i_rx_word(f_word), .i_rx_end(f_end), .i_rx_odd(1'b0),
      .i_rx_status(f_status), .i_rx_csum_err(4'h0), .o_rx_ready(),
      .o_rx_flow_ctrl(flow), .o_rx_csum_en(csum_en), .o_tx_hdr(hdr),
      .o_tx_valid(t_valid), .o_tx_last(t_last), .o_tx_ctrl(t_ctrl),
      .o_tx_count(t_count), .o_tx_word(t_word));
   fq_host fq_host_i (
      .i_mclk(clk), .i_arst_n(rst_n), .bus(link.host), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_big_endian(be), .o_busy(busy), .o_irq(irq), .i_tx_start(tx_start),
      .i_tx_ctrl(tx_ctrl), .i_tx_len(tx_len), .i_tx_valid(tx_valid),
      .i_tx_word(tx_word), .o_tx_ready(tx_ready), .i_rx_start(rx_start),
      .o_rx_valid(rx_valid), .o_rx_last(rx_last), .o_rx_word(rx_word),
      .o_rx_status(rx_status));
   fq_assertions fq_assertions_i (.i_mclk(clk), .i_arst_n(rst_n),
      .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
      .rdata(link.rdata), .big_endian(link.big_endian), .irq_n(link.irq_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Register port cycles; read data stands the cycle after the strobe
   task automatic wreg(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [8:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // One received frame of nw words from the switch side
   task automatic push(input int nw);
      st.push_back(16'($urandom));
      for (int i = 0; i < nw; i++) begin
         @(posedge clk);
         w = 16'($urandom);
         q.push_back(w);
         f_valid <= 1'b1;
         f_word <= w;
         f_end <= (i == nw - 1);
         f_status <= st[$];
      end
      @(posedge clk);
      f_valid <= 1'b0;
      f_end <= 1'b0;
   endtask
   // Each burst re-arms the data access so its first read is the dummy
   task automatic drain(input int left);
      wreg(fq_pkg::OFF_QCTL, 16'h0010);
      wreg(fq_pkg::OFF_QCTL, 16'h0018);
      @(posedge clk);
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      for (int i = 0; i < 900 && (q.size() > left || busy); i++) @(posedge clk);
      chk(16'(q.size()), 16'(left));
   endtask
   // Clock, cycle limit and result monitors
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (rx_valid) chk(rx_word, q.pop_front());
      if (rx_last) chk(rx_status, st.pop_front());
      if (hdr) chk(t_ctrl, tx_ctrl);
      if (hdr) chk({4'h0, t_count}, {4'h0, tx_len});
      if (t_valid) chk(t_word, tq.pop_front());
      if (t_valid) chk({15'h0, t_last}, {15'h0, tq.size() == 0});
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'h6BFD));
      {rst_n, wr, rd, tx_start, tx_valid, rx_start, f_valid, f_end} = 8'h00;
      {addr, wdata, f_word, f_status, tx_word, tx_ctrl, tx_len} = '0;
      be = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wreg(fq_pkg::OFF_RCR1, 16'h0401);
      wreg(fq_pkg::OFF_RCR2, 16'h000F);
      rreg(fq_pkg::OFF_RCR1, 16'h0401);
      chk({15'h0, flow}, 16'h0001);
      chk({12'h0, csum_en}, 16'h000F);
      rreg(9'h100, 16'h0000);
      wreg(fq_pkg::OFF_IER, 16'h2000);
      wreg(fq_pkg::OFF_DPTR, 16'h4000);
      wreg(fq_pkg::OFF_QCTL, 16'h0010);
      push(4);
      push(4);
      for (int i = 0; i < 20 && !irq; i++) @(posedge clk);
      chk({15'h0, irq}, 16'h0001);
      wreg(fq_pkg::OFF_ISR, 16'hFFFF);
      rreg(fq_pkg::OFF_RFC, 16'h0200);
      chk({15'h0, irq}, 16'h0000);
      rreg(fq_pkg::OFF_HSTAT, st[0]);
      rreg(fq_pkg::OFF_HCNT, 16'h0008);
      rreg(fq_pkg::OFF_HSTAT, st[1]);
      rreg(fq_pkg::OFF_HCNT, 16'h0008);
      drain(4);
      be <= 1'b1;
      drain(0);
      // Six-byte frame: three words, then one padding word of zero
      for (int i = 0; i < 3; i++) tq.push_back(16'($urandom));
      tq.push_back(16'h0000);
      @(posedge clk);
      tx_ctrl <= 16'($urandom);
      tx_len <= 12'h006;
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         tx_valid <= 1'b1;
         tx_word <= tq[i];
         @(negedge clk);
         while (!tx_ready) @(negedge clk);
         @(posedge clk);
      end
      tx_valid <= 1'b0;
      for (int i = 0; i < 200 && (tq.size() > 0 || busy); i++) @(posedge clk);
      chk(16'(tq.size()), 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: verilog/fq_device.sv */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fq_device #(
   parameter int DEPTH  = 2048,
   parameter int FRAMES = 16
) (
   // Clock and reset
   input  wire logic                      i_mclk,
   input  wire logic                      i_arst_n,
   // Host bus
   fq_if.dev                              bus,
   // Received frames from the switch
   input  wire logic                      i_rx_valid,
   input  wire logic [fq_pkg::DW-1:0]     i_rx_word,
   input  wire logic                      i_rx_end,
   input  wire logic                      i_rx_odd,
   input  wire logic [fq_pkg::DW-1:0]     i_rx_status,
   input  wire logic [fq_pkg::CSUM_N-1:0] i_rx_csum_err,
   output logic                           o_rx_ready,
   // Receive control levels
   output logic                           o_rx_flow_ctrl,
   output logic [fq_pkg::CSUM_N-1:0]      o_rx_csum_en,
   // Transmit frames toward the switch
   output logic                           o_tx_hdr,
   output logic                           o_tx_valid,
   output logic                           o_tx_last,
   output logic [fq_pkg::DW-1:0]          o_tx_ctrl,
   output logic [fq_pkg::BC_W-1:0]        o_tx_count,
   output logic [fq_pkg::DW-1:0]          o_tx_word
);
   localparam int PW = $clog2(DEPTH);
   localparam int FW = $clog2(FRAMES);
   localparam logic [PW-1:0] HDR_OFS = PW'(fq_pkg::HDR_WORDS);
   localparam logic [10:0] MAX_WORDS = 11'(fq_pkg::MAX_RX_BYTES / 2);

   logic [fq_pkg::DW-1:0]   mem [DEPTH];
   logic [fq_pkg::DW-1:0]   h_stat [FRAMES];
   logic [fq_pkg::BC_W-1:0] h_cnt [FRAMES];
   logic [PW-1:0]           h_base [FRAMES];

   logic [fq_pkg::DW-1:0] rcr1_r, rcr2_r, qc_r, dp_r, dtt_r, dbt_r;
   logic [fq_pkg::DW-1:0] ier_r, fct_r, rfc_r, hs_r, hbc_r, rdata_r;
   logic                  isr_rx_r, dummy_r;
   logic [2:0]            st_r;
   logic [1:0]            hseen_r;
   logic [FW-1:0]         h_wp_r, h_rp_r, hidx_r;
   logic [FW:0]           h_num_r;
   logic [PW-1:0]         mwp_r, fbase_r, mtail_r;
   logic [10:0]           fwords_r;
   logic [fq_pkg::BC_W-1:0] fbytes_r;
   logic [fq_pkg::DW-1:0] qbytes_r, age_r;
   logic [6:0]            us_r;
   logic [fq_pkg::BC_W-1:0] tx_idx_r, tx_need_r;

   // Bus decode
   wire wr = bus.wr;
   wire rd = bus.rd;
   wire [fq_pkg::DW-1:0] wd = bus.wdata;
   wire hit_data  = bus.addr == fq_pkg::OFF_DATA;
   wire dma_on    = qc_r[fq_pkg::QC_DMA];
   wire data_rd   = rd && hit_data && dma_on;
   wire data_wr   = wr && hit_data && dma_on;
   // Arm the dummy in the enabling write, so an immediate read is safe
   wire dma_rise  = wr && bus.addr == fq_pkg::OFF_QCTL &&
                    wd[fq_pkg::QC_DMA] && !dma_on;
   wire wr_isr    = wr && bus.addr == fq_pkg::OFF_ISR;
   wire clr_rx    = wr_isr && wd[fq_pkg::IRQ_RX];
   wire rd_rfc    = rd && bus.addr == fq_pkg::OFF_RFC;
   wire rd_hs     = rd && bus.addr == fq_pkg::OFF_HSTAT;
   wire rd_hbc    = rd && bus.addr == fq_pkg::OFF_HCNT;

   // Head frame read view
   wire have      = h_num_r != '0;
   wire [fq_pkg::BC_W-1:0] head_cnt = h_cnt[h_rp_r];
   wire [fq_pkg::BC_W-1:0] widx = {1'b0, dp_r[11:1]};
   wire [fq_pkg::BC_W-1:0] fr_end =
      fq_pkg::pad_words(head_cnt) + fq_pkg::BC_W'(fq_pkg::HDR_WORDS);
   wire [PW-1:0] maddr = h_base[h_rp_r] + PW'(widx) - HDR_OFS;
   wire [fq_pkg::DW-1:0] st_w = bus.big_endian ?
      fq_pkg::swap16(h_stat[h_rp_r]) : h_stat[h_rp_r];
   wire [fq_pkg::DW-1:0] bc_raw = {4'h0, head_cnt};
   wire [fq_pkg::DW-1:0] bc_w = bus.big_endian ?
      fq_pkg::swap16(bc_raw) : bc_raw;
   wire [fq_pkg::DW-1:0] q_word = !have ? fq_pkg::RST_ZERO :
      (widx == 12'd0) ? st_w : (widx == 12'd1) ? bc_w :
      mem[maddr];
   wire autoinc   = dp_r[fq_pkg::DP_AUTOINC];
   wire last_word = widx + 12'd1 >= fr_end;
   wire real_rd   = data_rd && !dummy_r && have;
   wire pop       = have && ((real_rd && autoinc && last_word &&
                    qc_r[fq_pkg::QC_AUTODEQ]) ||
                    (wr && bus.addr == fq_pkg::OFF_QCTL &&
                    wd[fq_pkg::QC_RELEASE]));

   // Frame intake; drop on enabled checksum error
   wire [fq_pkg::DW-1:0] mused = {{(fq_pkg::DW-PW){1'b0}}, mwp_r - mtail_r};
   assign o_rx_ready = rcr1_r[fq_pkg::RCR1_BLOCK] &&
      h_num_r < (FW+1)'(FRAMES) && mused < fq_pkg::DW'(DEPTH - 2);
   wire take     = i_rx_valid && o_rx_ready;
   wire store    = take && fwords_r < MAX_WORDS;
   wire csum_bad = |(i_rx_csum_err & rcr2_r[fq_pkg::CSUM_N-1:0]);
   wire fin      = take && i_rx_end;
   wire commit   = fin && !csum_bad;
   wire [fq_pkg::BC_W-1:0] add_b = i_rx_odd ? 12'd1 : 12'd2;
   wire [fq_pkg::BC_W-1:0] tot_b = fbytes_r + add_b;
   wire [fq_pkg::BC_W-1:0] fin_b =
      (tot_b > fq_pkg::MAX_RX_BYTES) ? fq_pkg::MAX_RX_BYTES : tot_b;
   assign o_rx_flow_ctrl = rcr1_r[fq_pkg::RCR1_FLOW];
   assign o_rx_csum_en   = rcr2_r[fq_pkg::CSUM_N-1:0];

   // Threshold conditions
   wire us_tick = us_r == 7'(fq_pkg::US_CYCLES - 1);
   wire fc_hit = qc_r[fq_pkg::QC_FC_EN] &&
      {{(15-FW){1'b0}}, h_num_r} > {8'h00, fct_r[7:0]};
   wire bc_hit = qc_r[fq_pkg::QC_BC_EN] && qbytes_r > dbt_r;
   wire dt_hit = qc_r[fq_pkg::QC_DT_EN] && have && age_r > dtt_r;
   wire [2:0] hits = {dt_hit, bc_hit, fc_hit};
   wire no_thr = qc_r[fq_pkg::QC_DT_EN:fq_pkg::QC_FC_EN] == 3'b000;
   wire rx_evt = |(hits & ~st_r) || (commit && no_thr);
   wire [FW-1:0] hsel = h_rp_r + hidx_r;
   wire [fq_pkg::DW-1:0] qc_rd = {3'b000, st_r, qc_r[9:0]};

   // Read data mux
   logic [fq_pkg::DW-1:0] rsel;
   always_comb begin
      rsel = fq_pkg::RST_ZERO;
      if (bus.addr == fq_pkg::OFF_RCR1) rsel = rcr1_r;
      else if (bus.addr == fq_pkg::OFF_RCR2) rsel = rcr2_r;
      else if (bus.addr == fq_pkg::OFF_HSTAT) rsel = hs_r;
      else if (bus.addr == fq_pkg::OFF_HCNT) rsel = hbc_r;
      else if (bus.addr == fq_pkg::OFF_QCTL) rsel = qc_rd;
      else if (bus.addr == fq_pkg::OFF_DPTR) rsel = dp_r;
      else if (bus.addr == fq_pkg::OFF_DTT) rsel = dtt_r;
      else if (bus.addr == fq_pkg::OFF_DBT) rsel = dbt_r;
      else if (bus.addr == fq_pkg::OFF_IER) rsel = ier_r;
      else if (bus.addr == fq_pkg::OFF_ISR)
         rsel = fq_pkg::DW'({isr_rx_r, 13'h0000});
      else if (bus.addr == fq_pkg::OFF_FCT) rsel = fct_r;
      else if (bus.addr == fq_pkg::OFF_RFC) rsel = rfc_r;
      else if (hit_data) rsel = dummy_r ? fq_pkg::RST_ZERO : q_word;
   end

   assign bus.rdata = rdata_r;
   assign bus.irq_n = !(isr_rx_r && ier_r[fq_pkg::IRQ_RX]);

   // Packet memory writes; no reset needed on the array
   always_ff @(posedge i_mclk) begin
      if (store) mem[mwp_r] <= i_rx_word;
      if (commit) begin
         h_stat[h_wp_r] <= i_rx_status;
         h_cnt[h_wp_r]  <= fin_b;
         h_base[h_wp_r] <= fbase_r;
      end
   end

   // Queue pointers; strict arrival order
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mwp_r <= '0; fbase_r <= '0; mtail_r <= '0;
         fwords_r <= '0; fbytes_r <= '0;
         h_wp_r <= '0; h_rp_r <= '0; h_num_r <= '0; qbytes_r <= '0;
      end else begin
         if (store) mwp_r <= mwp_r + PW'(1);
         if (take) begin
            fwords_r <= fin ? 11'd0 : fwords_r + 11'd1;
            fbytes_r <= fin ? 12'd0 : fin_b;
         end
         if (fin && csum_bad) mwp_r <= fbase_r;                     // Rewind
         else if (fin) fbase_r <= mwp_r + PW'(store);
         if (commit) h_wp_r <= h_wp_r + FW'(1);
         if (pop) begin
            h_rp_r  <= h_rp_r + FW'(1);
            mtail_r <= h_base[h_rp_r] + PW'((head_cnt + 12'd1) >> 1);
         end
         h_num_r  <= h_num_r + (FW+1)'(commit) - (FW+1)'(pop);
         qbytes_r <= qbytes_r + (commit ? {4'h0, fin_b} : 16'h0000)
                     - (pop ? bc_raw : 16'h0000);
      end
   end

   // Software registers
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rcr1_r <= '0; rcr2_r <= '0; qc_r <= '0; dtt_r <= '0;
         dbt_r <= '0; ier_r <= '0; fct_r <= '0;
      end else if (wr) begin
         if (bus.addr == fq_pkg::OFF_RCR1) rcr1_r <= wd;
         if (bus.addr == fq_pkg::OFF_RCR2) rcr2_r <= wd;
         if (bus.addr == fq_pkg::OFF_QCTL) qc_r <= wd & fq_pkg::QC_WMASK;
         if (bus.addr == fq_pkg::OFF_DTT) dtt_r <= wd;
         if (bus.addr == fq_pkg::OFF_DBT) dbt_r <= wd;
         if (bus.addr == fq_pkg::OFF_IER) ier_r <= wd;
         if (bus.addr == fq_pkg::OFF_FCT) fct_r <= {8'h00, wd[7:0]};
      end
   end

   // Data pointer, dummy read and duration timer
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dp_r <= '0; dummy_r <= 1'b1;
         us_r <= '0; age_r <= '0;
      end else begin
         if (dma_rise) dummy_r <= 1'b1;
         else if (data_rd) dummy_r <= 1'b0;
         if (wr && bus.addr == fq_pkg::OFF_DPTR) dp_r <= wd;
         else if (pop) dp_r <= dp_r & 16'h4000;
         else if (real_rd && autoinc) dp_r <= dp_r + 16'h0002;
         us_r <= us_tick ? 7'd0 : us_r + 7'd1;
         if (pop || !have) age_r <= '0;
         else if (us_tick && age_r != 16'hFFFF) age_r <= age_r + 16'h0001;
      end
   end

   // Interrupt status, threshold flags, frame count and headers
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         isr_rx_r <= 1'b0; st_r <= '0; rfc_r <= '0; hs_r <= '0;
         hbc_r <= '0; hseen_r <= '0; hidx_r <= '0; rdata_r <= '0;
      end else begin
         rdata_r <= rd ? rsel : fq_pkg::RST_ZERO;
         if (rx_evt) isr_rx_r <= 1'b1;
         else if (clr_rx) isr_rx_r <= 1'b0;
         st_r <= (clr_rx ? 3'b000 : st_r) | hits;           // Set wins
         if (clr_rx)
            rfc_r <= 16'(h_num_r) << fq_pkg::RFC_LSB;
         if (rd_rfc) begin
            hidx_r <= '0;
            hseen_r <= '0;
            hs_r <= h_stat[h_rp_r];
            hbc_r <= {4'h0, h_cnt[h_rp_r]};
         end else begin
            if ((hseen_r | {rd_hbc, rd_hs}) == 2'b11) begin
               hidx_r <= hidx_r + FW'(1);
               hseen_r <= '0;
               hs_r <= h_stat[hsel + FW'(1)];
               hbc_r <= {4'h0, h_cnt[hsel + FW'(1)]};
            end else hseen_r <= hseen_r | {rd_hbc, rd_hs};
         end
      end
   end

   // Transmit path: control, count, then padded data words
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_idx_r <= '0; tx_need_r <= '0; o_tx_hdr <= 1'b0;
         o_tx_valid <= 1'b0; o_tx_last <= 1'b0; o_tx_ctrl <= '0;
         o_tx_count <= '0; o_tx_word <= '0;
      end else begin
         o_tx_hdr <= 1'b0;
         o_tx_valid <= 1'b0;
         o_tx_last <= 1'b0;
         if (!dma_on) tx_idx_r <= '0;
         else if (data_wr) begin
            tx_idx_r <= tx_idx_r + 12'd1;
            if (tx_idx_r == 12'd0) o_tx_ctrl <= wd;
            else if (tx_idx_r == 12'd1) begin
               o_tx_count <= wd[fq_pkg::BC_W-1:0];
               o_tx_hdr <= 1'b1;
               tx_need_r <= fq_pkg::pad_words(wd[fq_pkg::BC_W-1:0])
                            + 12'd1;
            end else begin
               o_tx_valid <= 1'b1;
               o_tx_word <= wd;
               if (tx_idx_r == tx_need_r) begin
                  o_tx_last <= 1'b1;
                  tx_idx_r <= '0;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/fq_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fq_host (
   // Clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_arst_n,
   // Link to the device
   fq_if.host                           bus,
   // Plain register port
   input  wire logic [fq_pkg::AW-1:0]   i_reg_addr,
   input  wire logic [fq_pkg::DW-1:0]   i_reg_wdata,
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   output logic [fq_pkg::DW-1:0]        o_reg_rdata,
   input  wire logic                    i_big_endian,
   output logic                         o_busy,
   output logic                         o_irq,
   // Transmit frame feed
   input  wire logic                    i_tx_start,
   input  wire logic [fq_pkg::DW-1:0]   i_tx_ctrl,
   input  wire logic [fq_pkg::BC_W-1:0] i_tx_len,
   input  wire logic                    i_tx_valid,
   input  wire logic [fq_pkg::DW-1:0]   i_tx_word,
   output logic                         o_tx_ready,
   // Receive frame drain
   input  wire logic                    i_rx_start,
   output logic                         o_rx_valid,
   output logic                         o_rx_last,
   output logic [fq_pkg::DW-1:0]        o_rx_word,
   output logic [fq_pkg::DW-1:0]        o_rx_status
);
   typedef enum {IDLE, TX_CTRL, TX_CNT, TX_DATA, RX_ISSUE, RX_WAIT,
                 RX_TAKE} hst_t;
   hst_t st_r;
   logic [fq_pkg::BC_W-1:0] n_r, need_r, real_r, len_r;
   logic [fq_pkg::DW-1:0]   ctrl_r, e_wdata_r;
   logic                    e_wr_r, e_rd_r;

   // User strobes pass straight through while the engines rest
   wire idle = st_r == IDLE;
   assign bus.addr  = idle ? i_reg_addr : fq_pkg::OFF_DATA;
   assign bus.wdata = idle ? i_reg_wdata : e_wdata_r;
   assign bus.wr    = idle ? i_reg_wr : e_wr_r;
   assign bus.rd    = idle ? i_reg_rd : e_rd_r;
   assign bus.big_endian = i_big_endian;
   assign o_reg_rdata = bus.rdata;
   assign o_busy = !idle;
   assign o_irq = !bus.irq_n;
   assign o_tx_ready = st_r == TX_DATA && n_r < real_r && !e_wr_r;

   // Count word arrives swapped in big-endian mode
   wire [fq_pkg::DW-1:0] cnt_w = i_big_endian ?
      fq_pkg::swap16(bus.rdata) : bus.rdata;

   // Data register engines
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= IDLE; n_r <= '0; need_r <= '0; real_r <= '0;
         len_r <= '0; ctrl_r <= '0; e_wdata_r <= '0; e_wr_r <= 1'b0;
         e_rd_r <= 1'b0; o_rx_valid <= 1'b0; o_rx_last <= 1'b0;
         o_rx_word <= '0; o_rx_status <= '0;
      end else begin
         e_wr_r <= 1'b0;
         e_rd_r <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_last <= 1'b0;
         case (st_r)
            IDLE: begin
               n_r <= '0;
               if (i_tx_start) begin
                  st_r <= TX_CTRL;
                  ctrl_r <= i_tx_ctrl;
                  len_r <= i_tx_len;
                  real_r <= (i_tx_len + 12'd1) >> 1;
                  need_r <= fq_pkg::pad_words(i_tx_len);
               end else if (i_rx_start) st_r <= RX_ISSUE;
            end
            TX_CTRL: begin
               e_wr_r <= 1'b1;
               e_wdata_r <= ctrl_r;
               st_r <= TX_CNT;
            end
            TX_CNT: begin
               e_wr_r <= 1'b1;
               e_wdata_r <= {4'h0, len_r};
               st_r <= TX_DATA;
            end
            TX_DATA: begin
               if (n_r == need_r) st_r <= IDLE;
               else if (n_r >= real_r) begin
                  e_wr_r <= 1'b1;
                  e_wdata_r <= fq_pkg::RST_ZERO;
                  n_r <= n_r + 12'd1;
               end else if (o_tx_ready && i_tx_valid) begin
                  e_wr_r <= 1'b1;
                  e_wdata_r <= i_tx_word;
                  n_r <= n_r + 12'd1;
               end
            end
            RX_ISSUE: begin
               e_rd_r <= 1'b1;
               st_r <= RX_WAIT;
            end
            RX_WAIT: st_r <= RX_TAKE;
            RX_TAKE: begin
               n_r <= n_r + 12'd1;
               st_r <= RX_ISSUE;
               if (n_r == 12'd1) o_rx_status <= i_big_endian ?
                  fq_pkg::swap16(bus.rdata) : bus.rdata;
               else if (n_r == 12'd2)
                  need_r <= fq_pkg::pad_words(cnt_w[fq_pkg::BC_W-1:0])
                            + 12'd2;
               else if (n_r > 12'd2) begin
                  o_rx_valid <= 1'b1;
                  o_rx_word <= bus.rdata;
                  if (n_r == need_r) begin
                     o_rx_last <= 1'b1;
                     st_r <= IDLE;
                  end
               end
            end
            default: st_r <= IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: verilog/fq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fq_if;
   logic [fq_pkg::AW-1:0] addr;
   logic [fq_pkg::DW-1:0] wdata;
   logic                  wr;
   logic                  rd;
   logic [fq_pkg::DW-1:0] rdata;
   logic                  big_endian;
   logic                  irq_n;
   modport dev  (input addr, wdata, wr, rd, big_endian,
                 output rdata, irq_n);
   modport host (output addr, wdata, wr, rd, big_endian,
                 input rdata, irq_n);
endinterface
`default_nettype wire

/* File: verilog/fq_pkg.sv */
package fq_pkg;
   localparam int AW = 9;
   localparam int DW = 16;
   // Register offsets
   localparam logic [AW-1:0] OFF_RCR1  = 9'h174;
   localparam logic [AW-1:0] OFF_RCR2  = 9'h176;
   localparam logic [AW-1:0] OFF_HSTAT = 9'h17C;
   localparam logic [AW-1:0] OFF_HCNT  = 9'h17E;
   localparam logic [AW-1:0] OFF_QCTL  = 9'h182;
   localparam logic [AW-1:0] OFF_DPTR  = 9'h186;
   localparam logic [AW-1:0] OFF_DTT   = 9'h18C;
   localparam logic [AW-1:0] OFF_DBT   = 9'h18E;
   localparam logic [AW-1:0] OFF_IER   = 9'h190;
   localparam logic [AW-1:0] OFF_ISR   = 9'h192;
   localparam logic [AW-1:0] OFF_FCT   = 9'h19C;
   localparam logic [AW-1:0] OFF_RFC   = 9'h1B8;
   localparam logic [AW-1:0] OFF_DATA  = 9'h1C0;
   // Field positions
   localparam int QC_RELEASE = 0;
   localparam int QC_DMA     = 3;
   localparam int QC_AUTODEQ = 4;
   localparam int QC_FC_EN   = 5;
   localparam int QC_BC_EN   = 6;
   localparam int QC_DT_EN   = 7;
   localparam int QC_FC_ST   = 10;
   localparam int QC_BC_ST   = 11;
   localparam int QC_DT_ST   = 12;
   localparam logic [DW-1:0] QC_WMASK = 16'h00F8;
   localparam int RCR1_FLOW  = 10;
   localparam int RCR1_BLOCK = 0;
   localparam int DP_AUTOINC = 14;
   localparam int IRQ_RX     = 13;
   localparam int RFC_LSB    = 8;
   localparam int BC_W       = 12;
   localparam int CSUM_N     = 4;
   localparam int HDR_WORDS  = 2;
   // Sizes and timing
   localparam logic [BC_W-1:0] MAX_RX_BYTES = 12'd2000;
   localparam int CLK_NS    = 8;
   localparam int US_NS     = 1000;
   localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [DW-1:0] RST_ZERO = 16'h0000;

   // Words to move for a frame, padded to a double word
   function automatic logic [BC_W-1:0] pad_words(input logic [BC_W-1:0] c);
      logic [BC_W+1:0] s;
      s = {2'b00, c} + 14'h0003;
      pad_words = {s[BC_W:2], 1'b0};
   endfunction

   function automatic logic [DW-1:0] swap16(input logic [DW-1:0] w);
      swap16 = {w[7:0], w[15:8]};
   endfunction
endpackage
